// ### rtl/eepc_consts.vh
// Constants of the paged EEPROM host controller: pin timing, counts, unlock words.
// Assumes a 100 MHz system clock; included by the controller and its timer.
`ifndef EEPC_CONSTS_VH
`define EEPC_CONSTS_VH

// ----------------------------------------------------------------------------
// Clock and array geometry
// ----------------------------------------------------------------------------
`define EEPC_CLK_NS      10
`define EEPC_ADDR_W      17
`define EEPC_OFF_W       7
`define EEPC_PAGE_W      10
`define EEPC_DATA_W      8

// ----------------------------------------------------------------------------
// Pin timing in ns and derived cycle counts (least times round up)
// ----------------------------------------------------------------------------
`define EEPC_T_ACC_NS    200
`define EEPC_T_DF_NS     55
`define EEPC_T_WP_NS     200
`define EEPC_T_WPH_NS    100
`define EEPC_SYNC_CYC    2
`define EEPC_ACC_CYC     ((`EEPC_T_ACC_NS + `EEPC_CLK_NS - 1) / `EEPC_CLK_NS + `EEPC_SYNC_CYC)
`define EEPC_DF_CYC      ((`EEPC_T_DF_NS + `EEPC_CLK_NS - 1) / `EEPC_CLK_NS)
`define EEPC_WP_CYC      ((`EEPC_T_WP_NS + `EEPC_CLK_NS - 1) / `EEPC_CLK_NS)
`define EEPC_WPH_CYC     ((`EEPC_T_WPH_NS + `EEPC_CLK_NS - 1) / `EEPC_CLK_NS)

// ----------------------------------------------------------------------------
// Long times in microseconds, counted on a 1 us tick
// ----------------------------------------------------------------------------
`define EEPC_US_DIV      (1000 / `EEPC_CLK_NS)
`define EEPC_BOOT_US     5000
`define EEPC_BLC_US      150
`define EEPC_WC_US       10000
`define EEPC_TMR_W       14

// ----------------------------------------------------------------------------
// Unlock command words (arbitrary defaults, override per part)
// ----------------------------------------------------------------------------
`define EEPC_ULK_A0      17'h00001
`define EEPC_ULK_A1      17'h00002
`define EEPC_ULK_A2      17'h00003
`define EEPC_ULK_D0      8'h11
`define EEPC_ULK_D1      8'h22
`define EEPC_ULK_D2      8'h33

`endif

// ### rtl/eepc_host.v
// Host controller for a byte-wide paged EEPROM: reads, unlocked page writes, end-of-write polling.
// Assumes the EEPROM pins are wired directly; dq_in comes from the pad, asynchronous.
`timescale 1ns/1ps
`include "eepc_consts.vh"

// How it works
// [RULE1] Read: chip and output enables low, write enable high, sample the data pins.
// [RULE2] Data pins float whenever chip or output enable is high; we never contend then.
// [RULE3] One page write commits 1 to 128 bytes loaded into the device latch.
// [RULE4] Every write is preceded by three unlock command writes; protection never turns off.
// [RULE5] Address is set before the write strobe falls and held through the pulse. The code sets mem_addr on the same clock edge that drops the strobe.
// [RULE6] Write data is driven before and held after the write strobe rises.
// [RULE7] Each page byte follows the previous within 150 us, else loading ends.
// [RULE8] Page address stays fixed on every write strobe of one page load.
// [RULE9] Byte offset picks the byte; any order, rewrites allowed within the load.
// [RULE10] Only loaded bytes are programmed; the others of the page stay untouched.
// [RULE11] During programming the last byte reads back with its top bit inverted.
// [RULE12] Programming ends when true data returns; only then may a new write start. The code also accepts a new write after err_timeout.
// [RULE13] During programming the toggle bit changes on every read.
// [RULE14] After programming the toggle bit stops and reads return stored data.
// [RULE15] Writes are blocked for about 5 ms after power-up.
// [RULE16] No write starts while output enable is low or chip/write enable high.
// [RULE17] Strobe pulses shorter than about 15 ns never start a write.
// [RULE18] Unlock data is not stored; unlock addresses stay ordinary locations.
// [RULE19] A write without unlock only runs the timer; reads poll meanwhile.
// [RULE20] A page programming cycle lasts at most 10 ms.
// [RULE21] Main array is 131072 bytes behind a 17-bit address.
// [RULE22] A separate 128-byte area holds identification data.
// [RULE23] A new access starts only after the end of programming is seen. The code also returns to ready when the program timer expires (err_timeout).
// [RULE24] Protection re-arms after each cycle, so each write needs a fresh unlock.
// [RULE25] Host issues the three fixed unlock address/data pairs, then the page bytes.
module eepc_host #(
	parameter [`EEPC_TMR_W-1:0] BOOT_US = `EEPC_BOOT_US,
	parameter [`EEPC_TMR_W-1:0] BLC_US  = `EEPC_BLC_US,
	parameter [`EEPC_TMR_W-1:0] WC_US   = `EEPC_WC_US,
	parameter                   US_DIV  = `EEPC_US_DIV
) (
	input  wire                      clk_sys,
	input  wire                      rst_n,
	// User command side
	input  wire                      cmd_valid,
	input  wire                      cmd_write,
	input  wire                      cmd_toggle,
	input  wire [`EEPC_ADDR_W-1:0]   cmd_addr,
	output reg                       cmd_ready,
	input  wire                      wdata_valid,
	input  wire [`EEPC_OFF_W-1:0]    wdata_off,
	input  wire [`EEPC_DATA_W-1:0]   wdata,
	input  wire                      wdata_last,
	output reg                       wdata_ready,
	output reg  [`EEPC_DATA_W-1:0]   rd_data,
	output reg                       rd_valid,
	output reg                       wr_done,
	output reg                       err_timeout,
	output reg                       err_late,
	// EEPROM pins
	output reg                       chip_enable_n,
	output reg                       output_enable_n,
	output reg                       write_enable_n,
	output reg  [`EEPC_ADDR_W-1:0]   mem_addr,
	output reg  [`EEPC_DATA_W-1:0]   dq_out,
	output reg                       dq_oe,
	input  wire [`EEPC_DATA_W-1:0]   dq_in
);

	// ------------------------------------------------------------------------
	// States and registers
	// ------------------------------------------------------------------------
	localparam [7:0] S_BOOT  = 8'h01;
	localparam [7:0] S_IDLE  = 8'h02;
	localparam [7:0] S_RACC  = 8'h04;
	localparam [7:0] S_RGAP  = 8'h08;
	localparam [7:0] S_WLOW  = 8'h10;
	localparam [7:0] S_WHIGH = 8'h20;
	localparam [7:0] S_WAITB = 8'h40;
	localparam [7:0] S_POLL  = 8'h80;

	// Cycle counts cut to the width of cyc on purpose
	localparam [7:0]             WP_LEN   = `EEPC_WP_CYC - 1;
	localparam [7:0]             WPH_LEN  = `EEPC_WPH_CYC - 1;
	localparam [7:0]             ACC_LEN  = `EEPC_ACC_CYC;
	localparam [7:0]             DF_LEN   = `EEPC_DF_CYC;
	// Byte window counted from the strobe rise, one tick short so a late strobe still lands
	localparam [`EEPC_TMR_W-1:0] BLC_LOAD = BLC_US - 1;

	reg [7:0]                state;
	reg [7:0]                cyc;
	reg [1:0]                ulk_idx;
	reg                      polling;
	reg                      tog_mode;
	reg                      wlast;
	reg                      have_byte;
	reg                      have_prev;
	reg                      prev_tog;
	reg [`EEPC_PAGE_W-1:0]   page;
	reg [`EEPC_ADDR_W-1:0]   last_addr;
	reg [`EEPC_DATA_W-1:0]   last_data;
	reg [`EEPC_DATA_W-1:0]   cap;
	reg [`EEPC_DATA_W-1:0]   dq_s1;
	reg [`EEPC_DATA_W-1:0]   dq_s2;
	reg                      tmr_load;
	reg [`EEPC_TMR_W-1:0]    tmr_val;
	wire                     tmr_exp;

	// Unlock address for step idx
	function [`EEPC_ADDR_W-1:0] ulk_addr;
		input [1:0] idx;
		begin
			case (idx)
				2'd0:    ulk_addr = `EEPC_ULK_A0;
				2'd1:    ulk_addr = `EEPC_ULK_A1;
				default: ulk_addr = `EEPC_ULK_A2;
			endcase
		end
	endfunction

	// Unlock data for step idx
	function [`EEPC_DATA_W-1:0] ulk_data;
		input [1:0] idx;
		begin
			case (idx)
				2'd0:    ulk_data = `EEPC_ULK_D0;
				2'd1:    ulk_data = `EEPC_ULK_D1;
				default: ulk_data = `EEPC_ULK_D2;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------------
	// Long-time timer: power-up hold-off, byte window, program timeout
	// ------------------------------------------------------------------------
	eepc_tmr #(
		.DIV (US_DIV),
		.W   (`EEPC_TMR_W)
	) u_tmr (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_exp)
	);

	// Two-flop synchroniser on the data pins
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
		end else begin
			dq_s1 <= dq_in;
			dq_s2 <= dq_s1;
		end
	end

	// ------------------------------------------------------------------------
	// Main sequencer
	// ------------------------------------------------------------------------
	// Pins, handshakes and polling in one one-hot machine
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state           <= S_BOOT;
			cyc             <= 8'h00;
			ulk_idx         <= 2'd0;
			polling         <= 1'b0;
			tog_mode        <= 1'b0;
			wlast           <= 1'b0;
			have_byte       <= 1'b0;
			have_prev       <= 1'b0;
			prev_tog        <= 1'b0;
			page            <= {`EEPC_PAGE_W{1'b0}};
			last_addr       <= {`EEPC_ADDR_W{1'b0}};
			last_data       <= 8'h00;
			cap             <= 8'h00;
			tmr_load        <= 1'b1;
			tmr_val         <= BOOT_US;                          // RULE15
			cmd_ready       <= 1'b0;
			wdata_ready     <= 1'b0;
			rd_data         <= 8'h00;
			rd_valid        <= 1'b0;
			wr_done         <= 1'b0;
			err_timeout     <= 1'b0;
			err_late        <= 1'b0;
			chip_enable_n   <= 1'b1;
			output_enable_n <= 1'b1;
			write_enable_n  <= 1'b1;
			mem_addr        <= {`EEPC_ADDR_W{1'b0}};
			dq_out          <= 8'h00;
			dq_oe           <= 1'b0;
		end else begin
			tmr_load    <= 1'b0;
			rd_valid    <= 1'b0;
			wr_done     <= 1'b0;
			err_timeout <= 1'b0;
			err_late    <= 1'b0;
			if (cyc != 8'h00)
				cyc <= cyc - 8'h01;
			case (state)
				// Hold off all access until the power-up delay has run
				S_BOOT: begin
					if (tmr_exp && !tmr_load) begin                 // RULE15
						state     <= S_IDLE;
						cmd_ready <= 1'b1;
					end
				end
				// Accept a read or a page write
				S_IDLE: begin
					if (cmd_valid) begin                            // RULE23
						cmd_ready <= 1'b0;
						tog_mode  <= cmd_toggle;
						if (cmd_write) begin
							page           <= cmd_addr[`EEPC_ADDR_W-1:`EEPC_OFF_W];
							ulk_idx        <= 2'd0;
							have_byte      <= 1'b0;
							wlast          <= 1'b0;
							mem_addr       <= ulk_addr(2'd0);           // RULE4 RULE25
							dq_out         <= ulk_data(2'd0);
							dq_oe          <= 1'b1;
							chip_enable_n  <= 1'b0;                  // RULE16
							write_enable_n <= 1'b0;
							cyc            <= WP_LEN;                 // RULE17
							state          <= S_WLOW;
						end else begin
							polling         <= 1'b0;
							mem_addr        <= cmd_addr;             // RULE21
							chip_enable_n   <= 1'b0;                 // RULE1
							output_enable_n <= 1'b0;
							cyc             <= ACC_LEN;
							state           <= S_RACC;
						end
					end
				end
				// Write strobe low; address and data stay put
				S_WLOW: begin
					if (cyc == 8'h00) begin
						write_enable_n <= 1'b1;                      // RULE6
						cyc            <= WPH_LEN;
						tmr_load       <= 1'b1;                      // RULE7
						tmr_val        <= BLC_LOAD;
						state          <= S_WHIGH;
					end
				end
				// Strobe high: release data after one cycle of hold
				S_WHIGH: begin
					dq_oe <= 1'b0;                                  // RULE6
					if (cyc == 8'h00) begin
						if (ulk_idx < 2'd2) begin
							ulk_idx        <= ulk_idx + 2'd1;        // RULE4
							mem_addr       <= ulk_addr(ulk_idx + 2'd1);
							dq_out         <= ulk_data(ulk_idx + 2'd1);
							dq_oe          <= 1'b1;
							write_enable_n <= 1'b0;
							cyc            <= WP_LEN;
							state          <= S_WLOW;
						end else if (wlast) begin
							chip_enable_n <= 1'b1;
							state         <= S_POLL;                 // RULE3
						end else begin
							ulk_idx       <= 2'd3;
							chip_enable_n <= 1'b1;
							wdata_ready   <= 1'b1;
							state         <= S_WAITB;
						end
					end
				end
				// Wait for the next page byte inside the load window
				S_WAITB: begin
					if (tmr_exp && !tmr_load) begin
						wdata_ready <= 1'b0;                         // RULE7
						err_late    <= 1'b1;
						state       <= S_POLL;                       // RULE19
					end else if (wdata_valid) begin
						wdata_ready    <= 1'b0;
						have_byte      <= 1'b1;
						wlast          <= wdata_last;
						mem_addr       <= {page, wdata_off};             // RULE8 RULE9 RULE10
						last_addr      <= {page, wdata_off};
						last_data      <= wdata;
						dq_out         <= wdata;
						dq_oe          <= 1'b1;
						chip_enable_n  <= 1'b0;
						write_enable_n <= 1'b0;                      // RULE5
						cyc            <= WP_LEN;
						state          <= S_WLOW;
					end
				end
				// Start end-of-write detection on the last loaded byte, or on the third unlock address if no byte was loaded
				S_POLL: begin
					polling         <= 1'b1;
					have_prev       <= 1'b0;
					tmr_load        <= 1'b1;
					tmr_val         <= WC_US;                        // RULE20
					mem_addr        <= have_byte ? last_addr : ulk_addr(2'd2);
					chip_enable_n   <= 1'b0;
					output_enable_n <= 1'b0;
					cyc             <= ACC_LEN;
					state           <= S_RACC;
				end
				// Read access: wait access time plus synchroniser, then sample
				S_RACC: begin
					if (cyc == 8'h00) begin
						cap             <= dq_s2;
						chip_enable_n   <= 1'b1;                     // RULE2
						output_enable_n <= 1'b1;
						cyc             <= DF_LEN;
						state           <= S_RGAP;
						if (!polling) begin
							rd_data  <= dq_s2;
							rd_valid <= 1'b1;
						end
					end
				end
				// Float gap; judge a poll read and repeat if still busy
				S_RGAP: begin
					if (cyc == 8'h00) begin
						if (!polling) begin
							cmd_ready <= 1'b1;
							state     <= S_IDLE;
						end else if (tog_mode ? (have_prev && cap[6] == prev_tog)
						             : (cap[7] == last_data[7] || !have_byte)) begin
							wr_done   <= 1'b1;                       // RULE11 RULE12 RULE13 RULE14
							rd_data   <= cap;
							polling   <= 1'b0;
							cmd_ready <= 1'b1;                       // RULE24
							state     <= S_IDLE;
						end else if (tmr_exp && !tmr_load) begin
							err_timeout <= 1'b1;                     // RULE20
							polling     <= 1'b0;
							cmd_ready   <= 1'b1;
							state       <= S_IDLE;
						end else begin
							have_prev       <= 1'b1;
							prev_tog        <= cap[6];
							chip_enable_n   <= 1'b0;
							output_enable_n <= 1'b0;
							cyc             <= ACC_LEN;
							state           <= S_RACC;
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

endmodule // eepc_host

// ### rtl/eepc_tmr.v
// Microsecond down-timer with a built-in 1 us tick divider.
// Assumes one clock; load restarts the count, expired stays high until next load.
`timescale 1ns/1ps
`include "eepc_consts.vh"

module eepc_tmr #(
	parameter DIV = `EEPC_US_DIV,
	parameter W   = `EEPC_TMR_W
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire         load,
	input  wire [W-1:0] load_val,
	output reg          expired
);

	reg [7:0]   div;
	reg [W-1:0] cnt;
	wire        tick;

	assign tick = (div == DIV[7:0] - 8'h01);

	// ------------------------------------------------------------------------
	// Divider and count
	// ------------------------------------------------------------------------
	// Tick every DIV cycles; count ticks down to expiry
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			div     <= 8'h00;
			cnt     <= {W{1'b0}};
			expired <= 1'b0;
		end else if (load) begin
			div     <= 8'h00;
			cnt     <= load_val;
			expired <= 1'b0;
		end else begin
			div <= tick ? 8'h00 : div + 8'h01;
			if (tick && !expired) begin
				if (cnt <= {{(W-1){1'b0}}, 1'b1})
					expired <= 1'b1;
				else
					cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // eepc_tmr

// ### testbench/eepc_host_assertions.sv
// Checker on the controller ports: strobe legality, pulse width, page addressing, timing.
// Assumes one clock domain with synchronous active-low reset; attached by bind.
`timescale 1ns/1ps
`include "eepc_consts.vh"

module eepc_host_assertions #(
	parameter int BOOT_US = 5000,
	parameter int BLC_US  = 150,
	parameter int US_DIV  = 100
) (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        cmd_valid,
	input wire logic [16:0] cmd_addr,
	input wire logic        cmd_ready,
	input wire logic        wdata_valid,
	input wire logic [6:0]  wdata_off,
	input wire logic        wdata_ready,
	input wire logic        chip_enable_n,
	input wire logic        output_enable_n,
	input wire logic        write_enable_n,
	input wire logic [16:0] mem_addr,
	input wire logic [7:0]  dq_out,
	input wire logic        dq_oe
);
	int         low_cnt;
	int         boot_cnt;
	int         rdy_cnt;
	logic [9:0] page;
	logic [6:0] off;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Pulse, boot and window counters; page and offset of the load
	always @(posedge clk_sys) begin
		low_cnt <= write_enable_n ? 0 : low_cnt + 1;
		boot_cnt <= rst_n ? boot_cnt + 1 : 0;
		rdy_cnt <= wdata_ready ? rdy_cnt + 1 : 0;
		if (cmd_valid && cmd_ready) page <= cmd_addr[16:7];
		if (wdata_valid && wdata_ready) off <= wdata_off;
	end

	sequence s_take;
		wdata_valid && wdata_ready;
	endsequence
	sequence s_strobe;
		$fell(write_enable_n) && mem_addr == {page, off};
	endsequence

	AST_READ_PINS: assert property (!output_enable_n |-> write_enable_n && !chip_enable_n)
		else $error("read strobes illegal");
	AST_NO_CONTEND: assert property (!output_enable_n |-> !dq_oe)
		else $error("data driven during read");
	AST_WRITE_PINS: assert property (!write_enable_n |-> output_enable_n && !chip_enable_n && dq_oe)
		else $error("write strobes illegal");
	AST_PULSE: assert property ($rose(write_enable_n) |-> low_cnt == `EEPC_WP_CYC)
		else $error("write pulse width wrong");
	AST_HOLD: assert property (!write_enable_n ##1 !write_enable_n |-> $stable(mem_addr) && $stable(dq_out))
		else $error("address or data moved in pulse");
	AST_DATA_HOLD: assert property ($rose(write_enable_n) |-> dq_oe && $stable(dq_out))
		else $error("data released at strobe rise");
	AST_PAGE: assert property (s_take |-> ##[1:4] s_strobe)
		else $error("byte strobe not at page and offset");
	AST_BOOT: assert property (cmd_ready |-> boot_cnt >= (BOOT_US - 1) * US_DIV)
		else $error("ready before lockout ended");
	AST_WINDOW: assert property (wdata_ready |-> rdy_cnt <= (BLC_US + 1) * US_DIV + 2)
		else $error("byte window overran");
endmodule // eepc_host_assertions

// ### testbench/eepc_host_bench.sv
// Bench for the controller: lockout, page writes in both poll modes, late byte.
// Assumes the device model on the pins and the checker bound to the controller.
`timescale 1ns/1ps
`include "eepc_consts.vh"

module eepc_host_bench;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmd_valid = 1'b0;
	logic        cmd_write = 1'b0;
	logic        cmd_toggle = 1'b0;
	logic [16:0] cmd_addr = 17'h00000;
	logic        wdata_valid = 1'b0;
	logic        wdata_last = 1'b0;
	logic [6:0]  wdata_off = 7'h00;
	logic [7:0]  wdata = 8'h00;
	wire         cmd_ready, wdata_ready, rd_valid, wr_done, err_timeout, err_late;
	wire         ce_n, oe_n, we_n, dq_oe, dev_oe, fault;
	wire  [7:0]  rd_data, dq_out, dev_dq;
	wire  [16:0] mem_addr;
	int          errors = 0;
	int          comparisons = 0;
	// Data pins: host, device, else a pattern that changes on every clock edge, twice per cycle
	wire  [7:0]  pin = dq_oe ? dq_out : dev_oe ? dev_dq : 8'h5a ^ {8{clk_sys}};

	// Clock
	always #5 clk_sys = ~clk_sys;

	eepc_host #(.BOOT_US(14'd3), .BLC_US(14'd150), .WC_US(14'd400), .US_DIV(2)) dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_toggle(cmd_toggle), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
		.wdata_valid(wdata_valid), .wdata_off(wdata_off), .wdata(wdata),
		.wdata_last(wdata_last), .wdata_ready(wdata_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .wr_done(wr_done), .err_timeout(err_timeout),
		.err_late(err_late), .chip_enable_n(ce_n), .output_enable_n(oe_n),
		.write_enable_n(we_n), .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(pin));

	eepc_mem_model #(.BLC_NS(3000)) mdl_u (
		.chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n),
		.mem_addr(mem_addr), .pin(pin), .dev_dq(dev_dq), .dev_oe(dev_oe),
		.host_fault(fault));

	task automatic final_report;
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	function automatic logic sel(input int k);
		case (k)
			0: sel = cmd_ready === 1'b1;
			1: sel = wdata_ready === 1'b1;
			2: sel = rd_valid === 1'b1;
			default: sel = (wr_done | err_late | err_timeout) === 1'b1;
		endcase
	endfunction

	// Bounded wait for ready, byte request, read result or write end
	task automatic wait_on(input int k);
		int n;
		n = 0;
		while (!sel(k) && n < 3000) begin
			cyc(1);
			n++;
		end
		if (n == 3000) errors++;
	endtask

	task automatic send(input logic w, input logic t, input logic [16:0] a);
		wait_on(0);
		cmd_write = w;
		cmd_toggle = t;
		cmd_addr = a;
		cmd_valid = 1'b1;
		cyc(1);
		cmd_valid = 1'b0;
	endtask

	task automatic put(input logic [6:0] o, input logic [7:0] d, input logic l);
		wait_on(1);
		wdata_off = o;
		wdata = d;
		wdata_last = l;
		wdata_valid = 1'b1;
		cyc(1);
		wdata_valid = 1'b0;
		cyc(2);
	endtask

	task automatic rd(input logic [16:0] a, input logic [7:0] d);
		send(1'b0, 1'b0, a);
		wait_on(2);
		chk(rd_data, d);
	endtask

	// Lockout: no ready right after reset
	task automatic t_boot;
		cyc(2);
		chk(cmd_ready, 1'b0);
		wait_on(0);
	endtask

	// Page write: reordered and rewritten bytes, then read-back
	task automatic t_page(input logic t, input logic [9:0] p);
		send(1'b1, t, {p, 7'h00});
		put(7'h05, 8'ha1, 1'b0);
		put(7'h00, 8'h3c, 1'b0);
		put(7'h05, 8'h7e ^ {8{t}}, 1'b1);
		wait_on(3);
		chk({wr_done, err_timeout, err_late}, 3'b100);
		rd({p, 7'h05}, 8'h7e ^ {8{t}});
		rd({p, 7'h00}, 8'h3c);
		rd({p, 7'h01}, 8'hff);
	endtask

	// Late byte: window expires, loaded byte still programmed
	task automatic t_late;
		send(1'b1, 1'b0, 17'h1ff80);
		put(7'h7f, 8'h5a, 1'b0);
		wait_on(3);
		chk({wr_done, err_timeout, err_late}, 3'b001);
		cyc(1);
		wait_on(3);
		chk(wr_done, 1'b1);
		rd(17'h1ffff, 8'h5a);
	endtask

	// Main sequence
	initial begin
		cyc(2);
		rst_n = 1'b1;
		t_boot();
		t_page(1'b0, 10'h155);
		t_page(1'b1, 10'h2aa);
		rd(`EEPC_ULK_A0, 8'hff);
		t_late();
		chk(fault, 1'b0);
		final_report();
	end

	// Watchdog
	initial begin
		#200000;
		errors++;
		final_report();
	end
endmodule // eepc_host_bench

bind eepc_host eepc_host_assertions #(.BOOT_US(BOOT_US), .BLC_US(BLC_US), .US_DIV(US_DIV)) chk_u (
	.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
	.cmd_ready(cmd_ready), .wdata_valid(wdata_valid), .wdata_off(wdata_off),
	.wdata_ready(wdata_ready), .chip_enable_n(chip_enable_n),
	.output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
	.mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe));

// ### testbench/eepc_mem_model.sv
// Behavioural paged EEPROM: unlock words, page latch, timed programming, polling reads.
// Assumes the bench resolves the data pins; all times are in ns.
`timescale 1ns/1ps
`include "eepc_consts.vh"

module eepc_mem_model #(
	parameter int BOOT_NS = 40,
	parameter int BLC_NS  = 3000,
	parameter int PROG_NS = 1500,
	parameter int ACC_NS  = 150
) (
	input  wire logic        chip_enable_n,
	input  wire logic        output_enable_n,
	input  wire logic        write_enable_n,
	input  wire logic [16:0] mem_addr,
	input  wire logic [7:0]  pin,
	output wire logic [7:0]  dev_dq,
	output wire logic        dev_oe,
	output logic             host_fault = 1'b0
);
	logic [7:0]  mem [0:131071];
	logic [7:0]  id_area [0:127];
	logic [7:0]  lat [0:127];
	logic        lat_ok [0:127];
	logic [16:0] la = 17'h00000;
	logic [9:0]  page = 10'h000;
	logic [7:0]  last_d = 8'h00;
	logic [1:0]  ulk = 2'd0;
	logic        loading = 1'b0;
	logic        prog = 1'b0;
	logic        tog = 1'b0;
	realtime     t_fall = 0;
	realtime     t_load = 0;
	realtime     t_prog = 0;
	wire         busy = loading | prog;

	// Fixed unlock address and data pairs
	function automatic logic [24:0] pair(input logic [1:0] i);
		pair = (i == 2'd0) ? {`EEPC_ULK_A0, `EEPC_ULK_D0} :
			(i == 2'd1) ? {`EEPC_ULK_A1, `EEPC_ULK_D1} : {`EEPC_ULK_A2, `EEPC_ULK_D2};
	endfunction

	// Erased array and empty page latch
	initial begin
		for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
		for (int i = 0; i < 128; i++) lat_ok[i] = 1'b0;
	end

	// Reads: stored byte when idle, polling byte while busy
	assign dev_oe = !chip_enable_n && !output_enable_n && write_enable_n;
	assign #(ACC_NS) dev_dq = busy ? {~last_d[7], tog, last_d[5:0]} : mem[mem_addr];

	// Toggle bit flips on every read while busy
	always @(negedge output_enable_n) if (busy) tog = ~tog;

	// Address latch on the later falling strobe
	always @(negedge write_enable_n or negedge chip_enable_n) begin
		if (!write_enable_n && !chip_enable_n) begin
			la = mem_addr;
			t_fall = $realtime;
			if (!output_enable_n || prog) host_fault = 1'b1;
		end
	end

	// Data capture on the earlier rising strobe; short, inhibited or early pulses ignored
	always @(posedge write_enable_n or posedge chip_enable_n) begin
		if (write_enable_n != chip_enable_n && output_enable_n && !prog &&
			$realtime - t_fall >= 15 && $realtime >= BOOT_NS) begin
			if (!loading && ulk != 2'd3) begin
				if ({la, pin} == pair(ulk)) begin
					ulk = ulk + 2'd1;
				end else begin
					last_d = pin;
					prog = 1'b1;
					t_prog = $realtime;
					ulk = 2'd0;
				end
			end else begin
				if (loading && la[16:7] != page) host_fault = 1'b1;
				page = la[16:7];
				lat[la[6:0]] = pin;
				lat_ok[la[6:0]] = 1'b1;
				last_d = pin;
				loading = 1'b1;
				t_load = $realtime;
			end
		end
	end

	// Byte window expiry starts programming; a strobe begun inside the window still lands
	always #5 begin
		if (loading && $realtime - t_load >= BLC_NS && t_fall <= t_load) begin
			loading = 1'b0;
			prog = 1'b1;
			t_prog = $realtime;
		end
		if (prog && $realtime - t_prog >= PROG_NS) begin
			for (int i = 0; i < 128; i++) begin
				if (lat_ok[i]) mem[{page, i[6:0]}] = lat[i];
				lat_ok[i] = 1'b0;
			end
			prog = 1'b0;
			ulk = 2'd0;
		end
	end
endmodule // eepc_mem_model
